// ==== design/flow_sched.sv ====
// Headend upstream scheduling policy for one service flow: admission, polls, grants.
// Assumes modem-side events arrive from logic on the same clock, one cycle pulses.
//
// Chosen here: the APB register port and the register offsets.
`timescale 1ns/1ns
module flow_sched
	import flow_sched_pkg::*;
#(
	parameter longint BG_POLL_DEFAULT = BG_POLL_CYCLES
) (
	// Clock and reset
	input wire logic ref_clk_i,
	input wire logic rst_n_i,
	// APB slave
	input wire logic psel_i,
	input wire logic penable_i,
	input wire logic pwrite_i,
	input wire logic [7:0] paddr_i,
	input wire logic [31:0] pwdata_i,
	output logic pready_o,
	output logic [31:0] prdata_o,
	output logic pslverr_o,
	// Modem events
	input wire logic sync_valid_i,
	input wire logic [7:0] sync_header_i,
	input wire logic grant_used_i,
	input wire logic grant_unused_i,
	input wire logic restart_req_i,
	// Scheduler outputs
	output logic poll_o,
	output logic grant_o,
	output logic extra_grant_o
);

	typedef struct packed {
		apb_rsp_t rsp;
		logic enable;
		service_t svc;
		logic [31:0] policy;
		logic [31:0] poll_ivl;
		logic [31:0] grant_ivl;
		logic [6:0] gpi;
		logic [7:0] idle_limit;
		logic admitted;
		logic rejected;
		logic active;
		logic overrun;
		logic [6:0] agrants;
		logic [6:0] applied;
		logic [7:0] unused_cnt;
		logic [7:0] grants_left;
		logic extra_left;
		logic restart_extra;
		logic [9:0] credit;
		logic reload;
		sched_out_t out;
	} state_t;
	state_t st;
	state_t next_st;

	// Reset release through two flip-flops
	logic [1:0] rst_sync;
	logic rst_n;
	always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			rst_sync <= 2'h0;
		end else begin
			rst_sync <= {rst_sync[0], 1'b1};
		end
	end
	assign rst_n = rst_sync[1];
	apb_req_t req;
	grant_sync_header_t hdr;
	logic poll_tick;
	logic grant_tick;
	logic grants_mode;
	logic polls_mode;
	logic steady;
	logic admit_ok;
	logic [6:0] want;
	logic [31:0] rd;
	logic hit;
	assign req = '{psel: psel_i, penable: penable_i, pwrite: pwrite_i, paddr: paddr_i, pwdata: pwdata_i};
	assign hdr = grant_sync_header_t'(sync_header_i);
	// Which behaviour the flow runs now
	assign grants_mode = st.admitted && st.enable && (st.svc == fixed_grant_service ||
		(st.svc == fixed_grant_idle_detect_service && st.active));
	assign polls_mode = st.admitted && st.enable && (st.svc == periodic_poll_service ||
		st.svc == background_poll_service ||
		(st.svc == fixed_grant_idle_detect_service && !st.active));
	assign steady = (st.applied == st.agrants) && !st.restart_extra;

	// Poll and grant interval timers
	interval_tick #(.WIDTH(32)) poll_timer (
		.clk_i(ref_clk_i),
		.rst_n_i(rst_n),
		.run_i(polls_mode),
		.reload_i(st.reload),
		.period_i(st.poll_ivl),
		.tick_o(poll_tick)
	);
	interval_tick #(.WIDTH(32)) grant_timer (
		.clk_i(ref_clk_i),
		.rst_n_i(rst_n),
		.run_i(grants_mode),
		.reload_i(st.reload),
		.period_i(st.grant_ivl),
		.tick_o(grant_tick)
	);

	// Admission check on the stored policy and service type
	always_comb begin
		case (st.svc)
			periodic_poll_service,
			fixed_grant_service,
			fixed_grant_idle_detect_service: admit_ok = (st.policy[4:0] == POLICY_STRICT_MASK);
			background_poll_service,
			best_effort: admit_ok = (st.policy[2:0] == POLICY_OPEN_MASK);
			default: admit_ok = 1'b0;
		endcase
	end
	// Read mux
	always_comb begin
		rd = '0;
		hit = 1'b1;
		case (req.paddr)
			CTRL_OFF: rd = {28'h0, st.svc, st.enable};
			POLICY_OFF: rd = st.policy;
			ADMIT_OFF: rd = {30'h0, st.rejected, st.admitted};
			POLL_IVL_OFF: rd = st.poll_ivl;
			GRANT_IVL_OFF: rd = st.grant_ivl;
			GPI_OFF: rd = {25'h0, st.gpi};
			IDLE_LIMIT_OFF: rd = {24'h0, st.idle_limit};
			STATUS_OFF: begin
				rd[ST_ADMITTED_BIT] = st.admitted;
				rd[ST_REJECTED_BIT] = st.rejected;
				rd[ST_ACTIVE_BIT] = st.active;
				rd[ST_OVERRUN_BIT] = st.overrun;
				rd[ST_STEADY_BIT] = steady;
				rd[ST_AGRANTS_LSB +: 7] = st.agrants;
			end
			CREDIT_OFF: rd = {22'h0, st.credit};
			default: hit = 1'b0;
		endcase
	end
	// Active grant request clipped to the provisioned count
	assign want = (st.agrants > st.gpi) ? st.gpi : st.agrants;
	// Next state
	always_comb begin
		next_st = st;
		next_st.reload = 1'b0;
		next_st.out = '0;
		next_st.rsp.pready = 1'b0;
		next_st.rsp.pslverr = 1'b0;
		// APB: answer one cycle into the access phase
		if (req.psel && req.penable && !st.rsp.pready) begin
			next_st.rsp.pready = 1'b1;
			next_st.rsp.prdata = req.pwrite ? 32'h0 : rd;
			next_st.rsp.pslverr = !hit;
		end
		// Writes take effect at the edge that samples pready high
		if (req.psel && req.penable && st.rsp.pready && req.pwrite) begin
			case (req.paddr)
				CTRL_OFF: begin
					next_st.enable = req.pwdata[CTRL_EN_BIT];
					next_st.svc = service_t'(req.pwdata[CTRL_SVC_LSB +: 3]);
					next_st.admitted = 1'b0;
				end
				POLICY_OFF: begin
					next_st.policy = req.pwdata;
					next_st.admitted = 1'b0;
				end
				ADMIT_OFF: begin
					next_st.admitted = admit_ok;
					next_st.rejected = !admit_ok;
					next_st.active = 1'b1;
					next_st.agrants = st.gpi;
					next_st.unused_cnt = '0;
					next_st.reload = 1'b1;
				end
				POLL_IVL_OFF: next_st.poll_ivl = req.pwdata;
				GRANT_IVL_OFF: next_st.grant_ivl = req.pwdata;
				GPI_OFF: next_st.gpi = req.pwdata[6:0];
				IDLE_LIMIT_OFF: next_st.idle_limit = req.pwdata[7:0];
				default: next_st.enable = st.enable;
			endcase
		end
		// Sync header from the modem
		if (sync_valid_i && st.admitted) begin
			next_st.overrun = hdr.queue_overrun_flag;
			if (st.svc == fixed_grant_idle_detect_service) begin
				next_st.agrants = hdr.active_grants;
				if (hdr.active_grants == 7'h00) begin
					next_st.active = 1'b0;
				end
			end
		end
		// Unused grant tracking for idle detection
		if (grant_used_i) begin
			next_st.unused_cnt = '0;
		end else if (grant_unused_i && st.svc == fixed_grant_idle_detect_service && st.active) begin
			next_st.unused_cnt = st.unused_cnt + 8'h01;
			if (st.unused_cnt + 8'h01 >= st.idle_limit) begin
				next_st.active = 1'b0;
				next_st.unused_cnt = '0;
			end
		end
		// Restart request received in a poll opportunity
		if (restart_req_i && st.admitted && st.svc == fixed_grant_idle_detect_service && !st.active) begin
			next_st.active = 1'b1;
			next_st.restart_extra = 1'b1;
			next_st.unused_cnt = '0;
			next_st.reload = 1'b1;
		end
		// Polls only in poll mode, never while the flow is in grant mode
		if (poll_tick && polls_mode) begin
			next_st.out.poll = 1'b1;
		end
		// Start of a grant interval
		if (grant_tick && grants_mode) begin
			if (st.svc == fixed_grant_idle_detect_service) begin
				next_st.grants_left = {1'b0, want} + {7'h0, st.restart_extra};
				next_st.applied = want;
			end else begin
				next_st.grants_left = {1'b0, st.gpi};
				next_st.applied = st.agrants;
			end
			next_st.restart_extra = 1'b0;
			// Earn one credit per provisioned slot, capped at a three grant burst
			if (st.credit + {3'h0, st.gpi} > CREDIT_CAP) begin
				next_st.credit = CREDIT_CAP;
			end else begin
				next_st.credit = st.credit + {3'h0, st.gpi};
			end
			if (st.overrun && steady && next_st.credit >= EXTRA_COST) begin
				next_st.extra_left = 1'b1;
				next_st.credit = next_st.credit - EXTRA_COST;
			end
		end else if (grants_mode && st.grants_left != 8'h00) begin
			next_st.out.grant = 1'b1;
			next_st.grants_left = st.grants_left - 8'h01;
		end else if (grants_mode && st.extra_left) begin
			next_st.out.grant = 1'b1;
			next_st.out.extra = 1'b1;
			next_st.extra_left = 1'b0;
		end
		// Leaving grant mode drops what is queued
		if (!grants_mode) begin
			next_st.grants_left = '0;
			next_st.extra_left = 1'b0;
		end
	end

	// State register
	always_ff @(posedge ref_clk_i or negedge rst_n) begin
		if (!rst_n) begin
			st <= '0;
			st.svc <= best_effort;
			st.gpi <= GPI_RESET;
			st.idle_limit <= IDLE_LIMIT_RESET;
			st.grant_ivl <= GRANT_IVL_RESET;
			st.poll_ivl <= 32'(BG_POLL_DEFAULT);
		end else begin
			st <= next_st;
		end
	end
	assign pready_o = st.rsp.pready;
	assign prdata_o = st.rsp.prdata;
	assign pslverr_o = st.rsp.pslverr;
	assign poll_o = st.out.poll;
	assign grant_o = st.out.grant;
	assign extra_grant_o = st.out.extra;
	// Checks
	a_idle_exclusive: assert property (@(posedge ref_clk_i) disable iff (!rst_n)
		st.svc == fixed_grant_idle_detect_service |-> !(st.out.poll && st.out.grant))
		else $error("idle-detect flow polled and granted together");
	a_strict_reject: assert property (@(posedge ref_clk_i) disable iff (!rst_n)
		st.svc == periodic_poll_service && st.policy[4:0] != POLICY_STRICT_MASK |-> !st.admitted)
		else $error("periodic poll flow admitted with weak policy");
	a_idle_policy: assert property (@(posedge ref_clk_i) disable iff (!rst_n)
		st.svc == fixed_grant_idle_detect_service && st.policy[4:0] != POLICY_STRICT_MASK |-> !st.admitted)
		else $error("idle-detect flow admitted with weak policy");
	a_open_reject: assert property (@(posedge ref_clk_i) disable iff (!rst_n)
		(st.svc == background_poll_service || st.svc == best_effort) && st.policy[2:0] != POLICY_OPEN_MASK
		|-> !st.admitted)
		else $error("open flow admitted with restrictive policy");
	a_no_sched_unadmit: assert property (@(posedge ref_clk_i) disable iff (!rst_n)
		!$past(st.admitted) && !st.admitted |-> !st.out.poll && !st.out.grant)
		else $error("scheduling before admission");
	a_poll_on_tick: assert property (@(posedge ref_clk_i) disable iff (!rst_n)
		poll_tick && polls_mode |=> st.out.poll)
		else $error("poll opportunity missed on tick");
	a_grant_follows: assert property (@(posedge ref_clk_i) disable iff (!rst_n)
		grant_tick && grants_mode && st.gpi != 7'h00 && st.agrants != 7'h00 ##1 grants_mode |=> st.out.grant)
		else $error("grant missing after interval start");
	a_extra_steady: assert property (@(posedge ref_clk_i) disable iff (!rst_n)
		$rose(st.extra_left) |-> $past(st.overrun) && $past(st.applied == st.agrants))
		else $error("extra grant outside steady state");
	a_credit_cap: assert property (@(posedge ref_clk_i) disable iff (!rst_n)
		st.credit <= CREDIT_CAP)
		else $error("overrun credit above burst cap");
	a_idle_down: assert property (@(posedge ref_clk_i) disable iff (!rst_n)
		st.active && grant_unused_i && !grant_used_i && !restart_req_i && !(sync_valid_i)
		&& st.svc == fixed_grant_idle_detect_service && st.unused_cnt + 8'h01 >= st.idle_limit |=> !st.active)
		else $error("idle limit reached but flow stays active");
	a_restart_extra: assert property (@(posedge ref_clk_i) disable iff (!rst_n)
		$rose(st.active) && st.restart_extra |-> st.reload)
		else $error("restart without timer reload");

	c_reject: cover property (@(posedge ref_clk_i) disable iff (!rst_n) $rose(st.rejected));
	c_restart: cover property (@(posedge ref_clk_i) disable iff (!rst_n) $rose(st.restart_extra));
	c_extra: cover property (@(posedge ref_clk_i) disable iff (!rst_n) st.out.extra);
	c_go_idle: cover property (@(posedge ref_clk_i) disable iff (!rst_n) $fell(st.active));

endmodule : flow_sched

// ==== design/flow_sched_pkg.sv ====
// Shared constants and types for the upstream flow scheduling policy block.
// Assumes a single 25 MHz clock domain and an APB register port with 32-bit data.
package flow_sched_pkg;

	// Register byte offsets
	localparam logic [7:0] CTRL_OFF = 8'h00;
	localparam logic [7:0] POLICY_OFF = 8'h04;
	localparam logic [7:0] ADMIT_OFF = 8'h08;
	localparam logic [7:0] POLL_IVL_OFF = 8'h0C;
	localparam logic [7:0] GRANT_IVL_OFF = 8'h10;
	localparam logic [7:0] GPI_OFF = 8'h14;
	localparam logic [7:0] IDLE_LIMIT_OFF = 8'h18;
	localparam logic [7:0] STATUS_OFF = 8'h1C;
	localparam logic [7:0] CREDIT_OFF = 8'h20;

	// Field positions
	localparam int CTRL_EN_BIT = 0;
	localparam int CTRL_SVC_LSB = 1;
	localparam int ST_ADMITTED_BIT = 0;
	localparam int ST_REJECTED_BIT = 1;
	localparam int ST_ACTIVE_BIT = 2;
	localparam int ST_OVERRUN_BIT = 3;
	localparam int ST_STEADY_BIT = 4;
	localparam int ST_AGRANTS_LSB = 8;
	localparam int SYNC_OVERRUN_BIT = 7;

	// Policy word checks: low bits that must be all ones or all zeros
	localparam logic [4:0] POLICY_STRICT_MASK = 5'h1F;
	localparam logic [2:0] POLICY_OPEN_MASK = 3'h0;

	// Overrun compensation: one credit per provisioned slot, one percent means
	// one hundred credits per extra grant, burst capped at three grants
	localparam logic [9:0] EXTRA_COST = 10'h064;
	localparam logic [9:0] CREDIT_CAP = 10'h12C;

	// Reset values
	localparam logic [6:0] GPI_RESET = 7'h01;
	localparam logic [7:0] IDLE_LIMIT_RESET = 8'h04;
	localparam logic [31:0] GRANT_IVL_RESET = 32'h0000_01F4;

	// Background poll spacing: one second at 40 ns per cycle
	localparam longint CLK_PERIOD_NS = 40;
	localparam longint BG_POLL_NS = 1000000000;
	localparam longint BG_POLL_CYCLES = BG_POLL_NS / CLK_PERIOD_NS;

	// Scheduling service types
	typedef enum logic [2:0] {
		best_effort,
		background_poll_service,
		periodic_poll_service,
		fixed_grant_service,
		fixed_grant_idle_detect_service
	} service_t;

	// Grant sync header carried by modem packets
	typedef struct packed {
		logic queue_overrun_flag;
		logic [6:0] active_grants;
	} grant_sync_header_t;

	// APB request bundle
	typedef struct packed {
		logic psel;
		logic penable;
		logic pwrite;
		logic [7:0] paddr;
		logic [31:0] pwdata;
	} apb_req_t;

	// APB answer bundle
	typedef struct packed {
		logic pready;
		logic [31:0] prdata;
		logic pslverr;
	} apb_rsp_t;

	// Scheduler outputs toward the upstream map builder
	typedef struct packed {
		logic poll;
		logic grant;
		logic extra;
	} sched_out_t;

endpackage : flow_sched_pkg

// ==== design/interval_tick.sv ====
// Reloadable interval counter that emits a one-cycle tick each period.
// Assumes the period input is held stable by its owner between reloads.
`timescale 1ns/1ns
module interval_tick #(
	parameter int WIDTH = 32
) (
	// Clock and reset
	input wire logic clk_i,
	input wire logic rst_n_i,
	// Control
	input wire logic run_i,
	input wire logic reload_i,
	input wire logic [WIDTH-1:0] period_i,
	// Event
	output logic tick_o
);

	typedef struct packed {
		logic [WIDTH-1:0] count;
		logic tick;
	} tick_state_t;

	tick_state_t st;
	tick_state_t next_st;

	// Count down, tick on expiry and reload
	always_comb begin
		next_st = st;
		next_st.tick = 1'b0;
		if (!run_i || reload_i) begin
			next_st.count = period_i;
		end else if (st.count <= WIDTH'(1)) begin
			next_st.tick = 1'b1;
			next_st.count = period_i;
		end else begin
			next_st.count = st.count - WIDTH'(1);
		end
	end

	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			st <= '0;
		end else begin
			st <= next_st;
		end
	end

	assign tick_o = st.tick;

endmodule : interval_tick

// ==== sim/flow_sched_test.sv ====
// Self-checking bench for the flow scheduler: registers, admission, polls, grants.
// Assumes the modem model on the far side and a shortened background poll count.
`timescale 1ns/1ns
module flow_sched_test
	import flow_sched_pkg::*;
;
	logic ref_clk_i = 1'b0;
	logic rst_n_i = 1'b0;
	logic psel_i = 1'b0, penable_i = 1'b0, pwrite_i = 1'b0;
	logic [7:0] paddr_i = 8'h00;
	logic [31:0] pwdata_i = 32'h0000_0000;
	logic pready_o, pslverr_o, poll_o, grant_o, extra_grant_o;
	logic [31:0] prdata_o, q;
	logic sync_valid_i, grant_used_i, grant_unused_i, restart_req_i, e;
	logic [7:0] sync_header_i;
	logic want = 1'b0, ovr = 1'b0;
	logic [6:0] agr = 7'h01, gpi = 7'h01;
	int mismatches = 0, checks = 0, n_poll = 0, n_grant = 0, n_extra = 0;

	flow_sched #(.BG_POLL_DEFAULT(50)) u_flow_sched (.ref_clk_i(ref_clk_i), .rst_n_i(rst_n_i),
		.psel_i(psel_i), .penable_i(penable_i), .pwrite_i(pwrite_i), .paddr_i(paddr_i),
		.pwdata_i(pwdata_i), .pready_o(pready_o), .prdata_o(prdata_o), .pslverr_o(pslverr_o),
		.sync_valid_i(sync_valid_i), .sync_header_i(sync_header_i), .grant_used_i(grant_used_i),
		.grant_unused_i(grant_unused_i), .restart_req_i(restart_req_i), .poll_o(poll_o),
		.grant_o(grant_o), .extra_grant_o(extra_grant_o));
	modem_model u_modem_model (.ref_clk_i(ref_clk_i), .rst_n_i(rst_n_i), .poll_i(poll_o),
		.grant_i(grant_o), .want_active_i(want), .overrun_i(ovr), .agrants_i(agr), .gpi_i(gpi),
		.sync_valid_o(sync_valid_i), .sync_header_o(sync_header_i), .grant_used_o(grant_used_i),
		.grant_unused_o(grant_unused_i), .restart_req_o(restart_req_i));

	// Clock
	always #20 ref_clk_i = ~ref_clk_i;

	task automatic fail(input string m);
		mismatches++;
		$display("mismatch at %0t: %s", $time, m);
	endtask : fail

	task automatic close_out();
		$display("checks %0d mismatches %0d", checks, mismatches);
		if (mismatches == 0 && checks > 0) begin
			$display("Test passed");
		end else begin
			$display("Test failed");
		end
		$finish;
	endtask : close_out

	// Output monitor on settled values
	always @(negedge ref_clk_i) begin
		n_poll += (poll_o === 1'b1);
		n_grant += (grant_o === 1'b1);
		n_extra += (extra_grant_o === 1'b1);
		if (poll_o === 1'b1 && grant_o === 1'b1) fail("poll and grant together");
		if (extra_grant_o === 1'b1 && grant_o !== 1'b1) fail("extra without grant");
	end

	task automatic chk(input logic [31:0] g, input logic [31:0] x, input string m);
		checks++;
		if (g !== x) fail($sformatf("%s got %h want %h", m, g, x));
	endtask : chk

	task automatic chk_rng(input int g, input int lo, input int hi, input string m);
		checks++;
		if (g < lo || g > hi) fail($sformatf("%s got %0d want %0d..%0d", m, g, lo, hi));
	endtask : chk_rng

	// One APB transfer; entered just after a rising edge
	// Waits for pready however long it takes; only the watchdog ends a hung transfer
	task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
		psel_i <= 1'b1;
		pwrite_i <= wr;
		paddr_i <= a;
		pwdata_i <= d;
		@(posedge ref_clk_i);
		penable_i <= 1'b1;
		do begin
			@(posedge ref_clk_i);
		end while (pready_o !== 1'b1);
		q = prdata_o;
		e = pslverr_o;
		psel_i <= 1'b0;
		penable_i <= 1'b0;
		@(posedge ref_clk_i);
	endtask : apb

	function automatic logic [1:0] admit_exp(input int svc, input logic [31:0] p);
		logic ok;
		ok = (svc >= 2) ? (p[4:0] == POLICY_STRICT_MASK) : (p[2:0] == POLICY_OPEN_MASK);
		return {!ok, ok};
	endfunction : admit_exp

	task automatic setup(input int svc, input logic [31:0] p);
		apb(1'b1, CTRL_OFF, 32'(svc * 2 + 1));
		apb(1'b1, POLICY_OFF, p);
		apb(1'b1, ADMIT_OFF, 32'h0000_0000);
	endtask : setup

	task automatic measure(input int cyc);
		n_poll = 0;
		n_grant = 0;
		n_extra = 0;
		repeat (cyc) @(posedge ref_clk_i);
	endtask : measure

	// Watchdog
	initial begin
		repeat (30000) @(posedge ref_clk_i);
		fail("watchdog");
		close_out();
	end

	// Main sequence
	initial begin
		static logic [7:0] offs [7] = '{CTRL_OFF, POLICY_OFF, GPI_OFF, IDLE_LIMIT_OFF, GRANT_IVL_OFF, POLL_IVL_OFF, 8'h40};
		static logic [31:0] rv [7] = '{32'h0, 32'h0, 32'(GPI_RESET), 32'(IDLE_LIMIT_RESET), GRANT_IVL_RESET, 32'd50, 32'h0};
		int svc;
		logic [31:0] p;
		void'($urandom(32'hB396F54F));
		repeat (8) @(posedge ref_clk_i);
		rst_n_i <= 1'b1;
		repeat (3) @(posedge ref_clk_i);
		// Reset values and an unmapped place
		foreach (offs[i]) begin
			apb(1'b0, offs[i], 32'h0);
			chk(q, rv[i], "reset value");
			chk({31'h0, e}, {31'h0, offs[i] == 8'h40}, "slverr");
		end
		$display("test reset_values done");
		// Admission against random and corner policy words
		for (int i = 0; i < 40; i++) begin
			svc = i % 5;
			p = $urandom();
			if (i % 3 == 0) p[4:0] = (svc >= 2) ? 5'h1F : 5'h00;
			if (i % 7 == 0) p[i % 5] = ~p[i % 5];
			setup(svc, p);
			apb(1'b0, ADMIT_OFF, 32'h0);
			chk(q, {30'h0, admit_exp(svc, p)}, "admission");
		end
		$display("test admission done");
		// Polling services, and a refused flow that stays silent
		apb(1'b1, POLL_IVL_OFF, 32'd20);
		setup(2, 32'h0000_001F);
		measure(400);
		chk_rng(n_poll, 17, 21, "periodic polls");
		chk_rng(n_grant, 0, 0, "periodic grants");
		apb(1'b1, POLL_IVL_OFF, 32'd30);
		setup(1, 32'hFFFF_FFF8);
		measure(400);
		chk_rng(n_poll, 11, 14, "background polls");
		setup(2, 32'h0000_000F);
		measure(200);
		chk_rng(n_poll + n_grant, 0, 0, "refused flow");
		$display("test polling done");
		// Plain fixed grants ignore the active grants field
		apb(1'b1, GRANT_IVL_OFF, 32'd40);
		apb(1'b1, GPI_OFF, 32'd3);
		gpi <= 7'h03;
		want <= 1'b1;
		setup(3, 32'h0000_001F);
		measure(400);
		chk_rng(n_grant, 27, 33, "fixed grants");
		chk_rng(n_poll, 0, 0, "fixed polls");
		$display("test fixed_grant done");
		// Idle-detect: inactive polls, restart grants, overrun, idle again
		want <= 1'b0;
		apb(1'b1, POLL_IVL_OFF, 32'd20);
		setup(4, 32'hA5A5_A5FF);
		measure(300);
		measure(200);
		chk_rng(n_grant, 0, 0, "inactive grants");
		chk_rng(n_poll, 8, 11, "inactive polls");
		agr <= 7'h02;
		want <= 1'b1;
		measure(40);
		measure(400);
		chk_rng(n_grant, 18, 23, "active grants");
		chk_rng(n_poll, 0, 0, "active polls");
		// Zero active grants header sends the flow idle; a later poll restarts it
		agr <= 7'h00;
		measure(300);
		measure(200);
		chk_rng(n_grant, 0, 0, "zero header grants");
		chk_rng(n_poll, 8, 11, "zero header polls");
		agr <= 7'h02;
		measure(100);
		chk_rng(n_grant, 1, 3, "resumed grants");
		apb(1'b1, GRANT_IVL_OFF, 32'd120);
		apb(1'b1, GPI_OFF, 32'd50);
		gpi <= 7'h32;
		agr <= 7'h7F;
		ovr <= 1'b1;
		measure(600);
		measure(1200);
		chk_rng(n_extra, 1, 8, "overrun extras");
		chk_rng(n_grant, 500, 512, "overrun grants");
		apb(1'b0, STATUS_OFF, 32'h0000_0000);
		chk({31'h0, q[ST_OVERRUN_BIT]}, 32'h0000_0001, "overrun flag");
		chk({25'h0, q[ST_AGRANTS_LSB +: 7]}, 32'h0000_0032, "active grants field");
		ovr <= 1'b0;
		want <= 1'b0;
		measure(300);
		measure(200);
		chk_rng(n_grant, 0, 0, "idle again grants");
		chk_rng(n_poll, 8, 11, "idle again polls");
		apb(1'b0, STATUS_OFF, 32'h0000_0000);
		chk({30'h0, q[ST_ACTIVE_BIT], q[ST_ADMITTED_BIT]}, 32'h0000_0001, "idle status");
		$display("test idle_detect done");
		close_out();
	end
endmodule : flow_sched_test

// ==== sim/modem_model.sv ====
// Behavioural cable modem upstream MAC facing the flow scheduler.
// Assumes same-clock scheduler pulses; the bench sets activity and counts.
`timescale 1ns/1ns
module modem_model
	import flow_sched_pkg::*;
(
	// Clock and reset
	input wire logic ref_clk_i,
	input wire logic rst_n_i,
	// Scheduler opportunities
	input wire logic poll_i,
	input wire logic grant_i,
	// Traffic set by the bench
	input wire logic want_active_i,
	input wire logic overrun_i,
	input wire logic [6:0] agrants_i,
	input wire logic [6:0] gpi_i,
	// Modem events
	output logic sync_valid_o,
	output logic [7:0] sync_header_o,
	output logic grant_used_o,
	output logic grant_unused_o,
	output logic restart_req_o
);
	grant_sync_header_t hdr;
	logic quiet;
	logic live;

	// Header never asks for more than the provisioned grants per interval
	always_comb begin
		hdr.queue_overrun_flag = overrun_i;
		hdr.active_grants = (agrants_i > gpi_i) ? gpi_i : agrants_i;
		live = want_active_i && !quiet;
	end

	// Answer each grant, and each poll while grants are wanted, one cycle later; idle header lines toggle
	always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			quiet <= 1'b0;
			restart_req_o <= 1'b0;
			grant_used_o <= 1'b0;
			grant_unused_o <= 1'b0;
			sync_valid_o <= 1'b0;
			sync_header_o <= 8'h00;
		end else begin
			// One zero-grant packet, then silence until grants are wanted again
			quiet <= (agrants_i == 7'h00) && (quiet || (grant_i && want_active_i));
			restart_req_o <= poll_i && want_active_i && agrants_i != 7'h00;
			grant_used_o <= grant_i && live;
			grant_unused_o <= grant_i && !live;
			sync_valid_o <= grant_i && live;
			sync_header_o <= (grant_i && live) ? hdr : ~sync_header_o;
		end
	end
endmodule : modem_model
